//--- common/memory_ecc_diag_defs.svh
// register offsets, field positions and code constants of the memory ecc diagnostic unit
`ifndef MEMORY_ECC_DIAG_DEFS_SVH
`define MEMORY_ECC_DIAG_DEFS_SVH

// register offsets (byte addresses on the register port)
`define MEMCON_OFS_FIRST 16'h8000
`define MODE_DIAG_OFS 16'h8048
`define OWN_AM_OFS 16'h804c
`define WINDOW_SEL_BIT 15
`define WIN_IDX_LO 3

// memory configuration register fields
`define MEMCON_EN_BIT 31
`define MEMCON_BASE_HI 28
`define MEMCON_BASE_LO 24
`define MEMCON_BASE4_LO 26
`define MEMCON_SIG_HI 2
`define MEMCON_SIG_LO 1
`define MEMCON_RW_MASK 32'h9f000007
`define SIG_4MB 2'h2

// mode and diagnostic register fields
`define DIAG_DIS_BIT 0
`define DIAG_FAST_BIT 1
`define DIAG_PASS2_BIT 2
`define DIAG_FORCE_BIT 3
`define DIAG_CKB_LO 8
`define DIAG_CAP1_LO 16

// ownership address and mode register fields
`define OWN_SEG_LO 0
`define OWN_MASK_LO 12
`define OWN_MODE_LO 16
`define OWN_ST_CE_BIT 24
`define OWN_ST_FAIL_BIT 25
`define OWN_ST_UE_BIT 26

// code constants
`define POISON_MASK 8'h07
`define ODD_PARITY_MASK 8'h88
`define OWN_ALL_ZERO 12'h000
`define OWN_ALL_ONES 12'hfff
`define REG_RESET 32'h00000000

`endif

//--- common/memory_ecc_diag_pkg.sv
// types shared by the memory ecc diagnostic unit
package memory_ecc_diag_pkg;

  // ownership memory diagnostic access modes
  typedef enum logic [2:0] {
    OWN_RECON,
    OWN_TEST_ECC,
    OWN_TEST_FORCED,
    OWN_FAST_ECC,
    OWN_FAST_FORCED
  } own_mode_t;

  // decode result of one ownership memory location
  typedef struct packed {
    logic [7:0] data;
    logic ce;
    logic ue;
    logic fail;
  } own_check_t;

endpackage : memory_ecc_diag_pkg

//--- logic/data_ecc_core.sv
// check-bit generator and single-bit corrector for 64-bit data words
`include "memory_ecc_diag_defs.svh"

module data_ecc_core (
  // data word and stored check bits
  input wire logic [63:0] i_data,
  input wire logic [7:0] i_check,
  // generated code and decode result
  output logic [7:0] o_check,
  output logic [7:0] o_syndrome,
  output logic [63:0] o_data,
  output logic o_single,
  output logic o_uncorrectable
);
  localparam int HALF = 32;

  // column per data bit: weight 3 (or 5 in the upper half), distinct, never the poison value
  function automatic logic [7:0] code_column(input int idx);
    int n;
    int w;
    code_column = 8'h00;
    n = 0;
    for (int c = 1; c < 256; c++) begin
      w = $countones(c[7:0]);
      if (idx < HALF && !c[7] && w == 3 && c[7:0] != `POISON_MASK) begin
        if (n == idx) begin
          code_column = c[7:0];
        end
        n++;
      end else if (idx >= HALF && c[7] && (w == 3 || w == 5)) begin
        if (n == idx - HALF) begin
          code_column = c[7:0];
        end
        n++;
      end
    end
  endfunction : code_column

  logic [7:0] col_term [64];
  logic [63:0] hit;

  // per-bit contribution and syndrome match; s7 columns stay zero below bit 32 [R6] [R7]
  for (genvar i = 0; i < 64; i++) begin : g_bit
    localparam logic [7:0] COL = code_column(i);
    assign col_term[i] = i_data[i] ? COL : 8'h00;
    assign hit[i] = (o_syndrome == COL); // [R4]
  end

  // s3 and s7 start at one so they come out odd parity [R2] [R6]
  always_comb begin
    o_check = `ODD_PARITY_MASK;
    for (int i = 0; i < 64; i++) begin
      o_check = o_check ^ col_term[i];
    end
  end

  // the odd-parity offset cancels here, so a clean word gives zero [R3]
  assign o_syndrome = o_check ^ i_check;
  assign o_data = i_data ^ hit; // [R4]
  assign o_single = |hit;
  assign o_uncorrectable = (o_syndrome != 8'h00) && !o_single; // [R4]

endmodule : data_ecc_core

//--- logic/memory_ecc_diag_unit.sv
// ecc, nonexistent-memory and diagnostic logic of the memory controller
`include "memory_ecc_diag_defs.svh"

// Overview of operation
// R1 - address matching no enabled set still completes: read error cycle, write hard error
// R2 - every memory write stores check bits generated over the 64 data bits
// R3 - every read regenerates check bits; zero syndrome means the word is clean
// R4 - syndrome equal to a data column flips that bit; other nonzero is uncorrectable
// R5 - write parity error, illegal command or bad data command inverts check bits 2..0
// R6 - s0,s1,s2,s4,s5,s6 even parity, s3,s7 odd; s7 covers bits 63..32 only
// R7 - membership matrices are fixed tables chosen inside the design
// R8 - ownership location holds 8 bits plus 4 check bits; xor syndrome, column is correctable
// R9 - a location reading all zeros or all ones is flagged as failed
// R10 - a control bit disables data error detection independent of diagnostic modes
// R11 - fast test drives mode select bit 1 high, bit 0 too with second pass
// R12 - forced check-bit mode writes the register field instead of generated check bits
// R13 - check bits received on reads are captured into readable register fields
// R14 - capture only the first two transfers of every read, masked-write reads included
// R15 - software reads memory uncached then the diagnostic register right after
// R16 - window address bits 14..3 plus the segment number select the location
// R17 - the address and mode register holds a 3-bit mask selecting one ownership bit
// R18 - five window access modes; address and mode are loaded before window access
// R19 - reconstruction write updates only the masked bit; read returns bits 11..0
// R20 - test write stores bits 7..0 with generated check bits; read returns location
// R21 - fast test write stores 7..0 and 19..12 in two locations; read 11..0, 23..12
// R22 - forced test write stores bits 11..0 raw; read returns raw location
// R23 - fast forced write stores 11..0 and 23..12 raw in two locations; read both
module memory_ecc_diag_unit
  import memory_ecc_diag_pkg::*;
#(
  parameter int SETS = 8,
  parameter int SEG_W = 9,
  parameter int IDX_W = 12
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // register port
  input wire logic [15:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // memory transaction address check
  input wire logic i_txn_valid,
  input wire logic i_txn_write,
  input wire logic [28:0] i_txn_addr,
  output logic o_nxm_read_error,
  output logic o_nxm_hard_error,
  // write data path
  input wire logic i_mwr_valid,
  input wire logic [63:0] i_mwr_data,
  input wire logic i_mwr_parity_err,
  input wire logic i_mwr_illegal_cmd,
  input wire logic i_bad_write_data_cmd,
  output logic o_mem_we,
  output logic [63:0] o_mem_wdata,
  output logic [7:0] o_mem_wcheck,
  output logic [1:0] o_mode_sel,
  // read data path
  input wire logic i_mrd_valid,
  input wire logic [1:0] i_mrd_xfer,
  input wire logic [63:0] i_mrd_data,
  input wire logic [7:0] i_mrd_check,
  output logic o_rd_valid,
  output logic [63:0] o_rd_data,
  output logic o_rd_corrected,
  output logic o_rd_uncorrectable,
  output logic [7:0] o_rd_syndrome,
  // ownership memory port, asynchronous read, registered write
  output logic [SEG_W+IDX_W-1:0] o_own_raddr_a,
  output logic [SEG_W+IDX_W-1:0] o_own_raddr_b,
  input wire logic [11:0] i_own_rdata_a,
  input wire logic [11:0] i_own_rdata_b,
  output logic o_own_we_a,
  output logic o_own_we_b,
  output logic [SEG_W+IDX_W-1:0] o_own_waddr_a,
  output logic [SEG_W+IDX_W-1:0] o_own_waddr_b,
  output logic [11:0] o_own_wdata_a,
  output logic [11:0] o_own_wdata_b
);
  localparam int SET_W = $clog2(SETS);
  localparam int LOC_W = SEG_W + IDX_W;
  localparam logic [15:0] MEMCON_END = 16'(`MEMCON_OFS_FIRST + 4 * SETS);

  // ownership code columns; check bits are unit columns and count as uncorrectable
  function automatic logic [3:0] own_col(input int i);
    case (i)
      0: own_col = 4'h3;
      1: own_col = 4'h5;
      2: own_col = 4'h6;
      3: own_col = 4'h9;
      4: own_col = 4'ha;
      5: own_col = 4'hc;
      6: own_col = 4'h7;
      default: own_col = 4'hb;
    endcase
  endfunction : own_col

  function automatic logic [3:0] own_gen(input logic [7:0] d);
    own_gen = 4'h0;
    for (int i = 0; i < 8; i++) begin
      own_gen = own_gen ^ (d[i] ? own_col(i) : 4'h0);
    end
  endfunction : own_gen

  // syndrome, correction and stuck-pattern check of one location
  function automatic own_check_t own_decode(input logic [11:0] loc);
    logic [3:0] syn;
    own_decode = '0;
    syn = own_gen(loc[7:0]) ^ loc[11:8]; // [R8]
    own_decode.data = loc[7:0];
    for (int i = 0; i < 8; i++) begin
      if (syn == own_col(i)) begin
        own_decode.data[i] = ~loc[i];
        own_decode.ce = 1'b1;
      end
    end
    own_decode.ue = (syn != 4'h0) && !own_decode.ce;
    own_decode.fail = (loc == `OWN_ALL_ZERO) || (loc == `OWN_ALL_ONES); // [R9]
  endfunction : own_decode

  logic [31:0] memcon_reg [SETS];
  logic [SETS-1:0] set_hit;
  logic dis_reg, fast_reg, pass2_reg, force_reg;
  logic [7:0] ckb_reg, cap1_reg;
  logic [SEG_W-1:0] own_seg_reg;
  logic [2:0] own_mask_reg, own_mode_reg;
  logic own_ce_reg, own_fail_reg, own_ue_reg;
  logic [7:0] gen_check, rd_syndrome;
  logic [63:0] rd_fixed;
  logic rd_single, rd_uncorr;
  logic [31:0] diag_rd, own_am_rd, win_rd, rd_mux;
  logic win_we_a, win_we_b;
  logic [11:0] win_wdata_a, win_wdata_b;
  logic [7:0] recon_data;

  // register port decode
  wire logic memcon_hit = (i_reg_addr >= `MEMCON_OFS_FIRST) && (i_reg_addr < MEMCON_END)
                          && (i_reg_addr[1:0] == 2'h0);
  wire logic [SET_W-1:0] memcon_idx = i_reg_addr[2 +: SET_W];
  wire logic diag_hit = (i_reg_addr == `MODE_DIAG_OFS);
  wire logic own_am_hit = (i_reg_addr == `OWN_AM_OFS);
  wire logic win_hit = !i_reg_addr[`WINDOW_SEL_BIT];
  wire logic diag_wr = i_reg_wr && diag_hit;
  wire logic own_am_wr = i_reg_wr && own_am_hit;
  wire logic win_wr = i_reg_wr && win_hit;
  wire logic win_rd_stb = i_reg_rd && win_hit;

  // per-set configuration storage and base address compare
  for (genvar s = 0; s < SETS; s++) begin : g_set
    wire logic is_4mb = (memcon_reg[s][`MEMCON_SIG_HI:`MEMCON_SIG_LO] == `SIG_4MB);
    wire logic hit_1mb = (memcon_reg[s][`MEMCON_BASE_HI:`MEMCON_BASE_LO]
                          == i_txn_addr[`MEMCON_BASE_HI:`MEMCON_BASE_LO]);
    wire logic hit_4mb = (memcon_reg[s][`MEMCON_BASE_HI:`MEMCON_BASE4_LO]
                          == i_txn_addr[`MEMCON_BASE_HI:`MEMCON_BASE4_LO]);
    assign set_hit[s] = memcon_reg[s][`MEMCON_EN_BIT] && (is_4mb ? hit_4mb : hit_1mb); // [R1]
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        memcon_reg[s] <= `REG_RESET;
      end else if (i_reg_wr && memcon_hit && memcon_idx == SET_W'(s)) begin
        memcon_reg[s] <= i_reg_wdata & `MEMCON_RW_MASK;
      end
    end
  end

  // nonexistent memory: the transaction is still answered, only flagged
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_nxm_read_error <= 1'b0;
      o_nxm_hard_error <= 1'b0;
    end else begin
      o_nxm_read_error <= i_txn_valid && !i_txn_write && !(|set_hit); // [R1]
      o_nxm_hard_error <= i_txn_valid && i_txn_write && !(|set_hit); // [R1]
    end
  end

  // write path: generated or forced check bits, then poisoning on bad write data
  data_ecc_core u_wr_ecc (
    .i_data(i_mwr_data),
    .i_check(8'h00),
    .o_check(gen_check),
    .o_syndrome(),
    .o_data(),
    .o_single(),
    .o_uncorrectable()
  );
  wire logic wr_poison = i_mwr_parity_err || i_mwr_illegal_cmd || i_bad_write_data_cmd;
  wire logic [7:0] wr_base_check = force_reg ? ckb_reg : gen_check; // [R2] [R12]
  wire logic [7:0] wr_check = wr_base_check ^ (wr_poison ? `POISON_MASK : 8'h00); // [R5]

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mem_we <= 1'b0;
      o_mem_wdata <= '0;
      o_mem_wcheck <= '0;
    end else begin
      o_mem_we <= i_mwr_valid;
      if (i_mwr_valid) begin
        o_mem_wdata <= i_mwr_data;
        o_mem_wcheck <= wr_check;
      end
    end
  end

  // bank mode select follows the flopped diagnostic bits on every access
  assign o_mode_sel = {fast_reg, fast_reg && pass2_reg}; // [R11]

  // read path; the detect-disable bit lets check-bit drams be tested with raw data
  data_ecc_core u_rd_ecc (
    .i_data(i_mrd_data),
    .i_check(i_mrd_check),
    .o_check(),
    .o_syndrome(rd_syndrome),
    .o_data(rd_fixed),
    .o_single(rd_single),
    .o_uncorrectable(rd_uncorr)
  );

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
      o_rd_corrected <= 1'b0;
      o_rd_uncorrectable <= 1'b0;
      o_rd_syndrome <= '0;
    end else begin
      o_rd_valid <= i_mrd_valid;
      if (i_mrd_valid) begin
        o_rd_data <= dis_reg ? i_mrd_data : rd_fixed; // [R4] [R10]
        o_rd_corrected <= !dis_reg && rd_single; // [R4] [R10]
        o_rd_uncorrectable <= !dis_reg && rd_uncorr; // [R4] [R10]
        o_rd_syndrome <= rd_syndrome; // [R3]
      end
    end
  end

  // diagnostic register; a capture in the same cycle as a write wins
  wire logic cap0 = i_mrd_valid && (i_mrd_xfer == 2'h0); // [R14]
  wire logic cap1 = i_mrd_valid && (i_mrd_xfer == 2'h1); // [R14]
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dis_reg <= 1'b0;
      fast_reg <= 1'b0;
      pass2_reg <= 1'b0;
      force_reg <= 1'b0;
      ckb_reg <= '0;
      cap1_reg <= '0;
    end else begin
      if (diag_wr) begin
        dis_reg <= i_reg_wdata[`DIAG_DIS_BIT];
        fast_reg <= i_reg_wdata[`DIAG_FAST_BIT];
        pass2_reg <= i_reg_wdata[`DIAG_PASS2_BIT];
        force_reg <= i_reg_wdata[`DIAG_FORCE_BIT];
      end
      if (cap0) begin
        ckb_reg <= i_mrd_check; // [R13]
      end else if (diag_wr) begin
        ckb_reg <= i_reg_wdata[`DIAG_CKB_LO +: 8];
      end
      if (cap1) begin
        cap1_reg <= i_mrd_check; // [R13]
      end
    end
  end

  // ownership window: segment plus window index pick the location pair
  wire logic [LOC_W-1:0] own_loc_a = {own_seg_reg, i_reg_addr[`WIN_IDX_LO +: IDX_W]}; // [R16]
  wire logic [LOC_W-1:0] own_loc_b = own_loc_a + {{(LOC_W-1){1'b0}}, 1'b1};
  assign o_own_raddr_a = own_loc_a;
  assign o_own_raddr_b = own_loc_b;
  wire own_check_t dec_a = own_decode(i_own_rdata_a);
  wire own_check_t dec_b = own_decode(i_own_rdata_b);
  wire own_mode_t own_mode = own_mode_t'(own_mode_reg);
  wire logic fast_pair = (own_mode == OWN_FAST_ECC) || (own_mode == OWN_FAST_FORCED);

  // merge the masked bit into the corrected location for reconstruction
  always_comb begin
    recon_data = dec_a.data;
    recon_data[own_mask_reg] = i_reg_wdata[0]; // [R17] [R19]
  end

  // window write data and read data per access mode; unknown modes do nothing
  always_comb begin
    win_we_a = 1'b0;
    win_we_b = 1'b0;
    win_wdata_a = '0;
    win_wdata_b = '0;
    win_rd = '0;
    case (own_mode) // [R18]
      OWN_RECON: begin
        win_we_a = 1'b1;
        win_wdata_a = {own_gen(recon_data), recon_data}; // [R19]
        win_rd[11:0] = i_own_rdata_a;
      end
      OWN_TEST_ECC: begin
        win_we_a = 1'b1;
        win_wdata_a = {own_gen(i_reg_wdata[7:0]), i_reg_wdata[7:0]}; // [R20]
        win_rd[11:0] = i_own_rdata_a;
      end
      OWN_TEST_FORCED: begin
        win_we_a = 1'b1;
        win_wdata_a = i_reg_wdata[11:0]; // [R22]
        win_rd[11:0] = i_own_rdata_a;
      end
      OWN_FAST_ECC: begin
        win_we_a = 1'b1;
        win_we_b = 1'b1;
        win_wdata_a = {own_gen(i_reg_wdata[7:0]), i_reg_wdata[7:0]}; // [R21]
        win_wdata_b = {own_gen(i_reg_wdata[19:12]), i_reg_wdata[19:12]}; // [R21]
        win_rd[23:0] = {i_own_rdata_b, i_own_rdata_a};
      end
      OWN_FAST_FORCED: begin
        win_we_a = 1'b1;
        win_we_b = 1'b1;
        win_wdata_a = i_reg_wdata[11:0]; // [R23]
        win_wdata_b = i_reg_wdata[23:12]; // [R23]
        win_rd[23:0] = {i_own_rdata_b, i_own_rdata_a};
      end
      default: begin
        win_rd = '0;
      end
    endcase
  end

  // ownership memory write is issued the cycle after the window write
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_own_we_a <= 1'b0;
      o_own_we_b <= 1'b0;
      o_own_waddr_a <= '0;
      o_own_waddr_b <= '0;
      o_own_wdata_a <= '0;
      o_own_wdata_b <= '0;
    end else begin
      o_own_we_a <= win_wr && win_we_a;
      o_own_we_b <= win_wr && win_we_b;
      if (win_wr) begin
        o_own_waddr_a <= own_loc_a;
        o_own_waddr_b <= own_loc_b;
        o_own_wdata_a <= win_wdata_a;
        o_own_wdata_b <= win_wdata_b;
      end
    end
  end

  // address and mode register; window reads refresh the location status
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      own_seg_reg <= '0;
      own_mask_reg <= '0;
      own_mode_reg <= '0;
      own_ce_reg <= 1'b0;
      own_fail_reg <= 1'b0;
      own_ue_reg <= 1'b0;
    end else if (own_am_wr) begin
      own_seg_reg <= i_reg_wdata[`OWN_SEG_LO +: SEG_W];
      own_mask_reg <= i_reg_wdata[`OWN_MASK_LO +: 3];
      own_mode_reg <= i_reg_wdata[`OWN_MODE_LO +: 3];
      own_ce_reg <= 1'b0;
      own_fail_reg <= 1'b0;
      own_ue_reg <= 1'b0;
    end else if (win_rd_stb) begin
      own_ce_reg <= dec_a.ce || (fast_pair && dec_b.ce); // [R8]
      own_fail_reg <= dec_a.fail || (fast_pair && dec_b.fail); // [R9]
      own_ue_reg <= dec_a.ue || (fast_pair && dec_b.ue);
    end
  end

  // readback images
  always_comb begin
    diag_rd = '0;
    diag_rd[`DIAG_DIS_BIT] = dis_reg;
    diag_rd[`DIAG_FAST_BIT] = fast_reg;
    diag_rd[`DIAG_PASS2_BIT] = pass2_reg;
    diag_rd[`DIAG_FORCE_BIT] = force_reg;
    diag_rd[`DIAG_CKB_LO +: 8] = ckb_reg;
    diag_rd[`DIAG_CAP1_LO +: 8] = cap1_reg;
    own_am_rd = '0;
    own_am_rd[`OWN_SEG_LO +: SEG_W] = own_seg_reg;
    own_am_rd[`OWN_MASK_LO +: 3] = own_mask_reg;
    own_am_rd[`OWN_MODE_LO +: 3] = own_mode_reg;
    own_am_rd[`OWN_ST_CE_BIT] = own_ce_reg;
    own_am_rd[`OWN_ST_FAIL_BIT] = own_fail_reg;
    own_am_rd[`OWN_ST_UE_BIT] = own_ue_reg;
  end

  // unmapped addresses read as zero
  assign rd_mux = win_hit ? win_rd :
                  memcon_hit ? memcon_reg[memcon_idx] :
                  diag_hit ? diag_rd :
                  own_am_hit ? own_am_rd : `REG_RESET;

  // read data stand for the one cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= `REG_RESET;
    end else begin
      o_reg_rdata <= i_reg_rd ? rd_mux : `REG_RESET;
    end
  end

  // checks on the guarded behaviour
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  a_nxm_read: assert property (i_txn_valid && !i_txn_write && set_hit == '0 // [R1]
    |=> o_nxm_read_error && !o_nxm_hard_error) else $error("nxm read not flagged");
  a_nxm_write: assert property (i_txn_valid && i_txn_write && set_hit == '0 // [R1]
    |=> o_nxm_hard_error && !o_nxm_read_error) else $error("nxm write not flagged");
  a_gen_check: assert property (i_mwr_valid && !force_reg && !wr_poison // [R2]
    |=> o_mem_we && o_mem_wcheck == $past(gen_check)) else $error("bad generated check");
  a_poison_lsbs: assert property (i_mwr_valid && !force_reg && wr_poison // [R5]
    |=> o_mem_wcheck == ($past(gen_check) ^ `POISON_MASK)) else $error("poison missing");
  a_clean_read: assert property (i_mrd_valid && rd_syndrome == 8'h00 // [R3]
    |=> o_rd_valid && !o_rd_corrected && !o_rd_uncorrectable
        && o_rd_data == $past(i_mrd_data)) else $error("clean read altered");
  a_single_fix: assert property (i_mrd_valid && !dis_reg && rd_single // [R4]
    |=> o_rd_corrected && $countones(o_rd_data ^ $past(i_mrd_data)) == 1)
    else $error("single error not corrected");
  a_detect_off: assert property (i_mrd_valid && dis_reg // [R10]
    |=> !o_rd_corrected && !o_rd_uncorrectable && o_rd_data == $past(i_mrd_data))
    else $error("detection not disabled");
  a_fast_select: assert property (diag_wr && i_reg_wdata[`DIAG_FAST_BIT] // [R11]
    |=> o_mode_sel[1] && o_mode_sel[0] == $past(i_reg_wdata[`DIAG_PASS2_BIT]))
    else $error("mode select wrong");
  a_forced_ckb: assert property (i_mwr_valid && force_reg && !wr_poison && !cap0 // [R12]
    |=> o_mem_wcheck == $past(ckb_reg)) else $error("forced check bits not used");
  a_capture_first: assert property (cap0 |=> ckb_reg == $past(i_mrd_check)) // [R13]
    else $error("check bits not captured");
  a_capture_late: assert property (i_mrd_valid && i_mrd_xfer[1] && !diag_wr // [R14]
    |=> $stable(ckb_reg) && $stable(cap1_reg)) else $error("late transfer captured");
  a_own_fail: assert property (win_rd_stb && !own_am_wr && i_own_rdata_a == `OWN_ALL_ZERO // [R9]
    |=> own_fail_reg) else $error("stuck location not flagged");
  a_win_forced: assert property (win_wr && own_mode == OWN_TEST_FORCED // [R22]
    |=> o_own_we_a && !o_own_we_b && o_own_wdata_a == $past(i_reg_wdata[11:0]))
    else $error("forced window write wrong");
  a_fast_pair: assert property (win_wr && fast_pair // [R21]
    |=> o_own_we_a && o_own_we_b && o_own_waddr_b == o_own_waddr_a + 1'b1)
    else $error("fast pair write wrong");

  c_nxm_read: cover property (i_txn_valid && !i_txn_write && set_hit == '0 ##1 o_nxm_read_error);
  c_corrected: cover property (i_mrd_valid && !dis_reg && rd_single ##1 o_rd_corrected);
  c_poison: cover property (i_mwr_valid && wr_poison ##1 o_mem_we);
  c_fast_window: cover property (win_wr && own_mode == OWN_FAST_FORCED ##1 o_own_we_b);

endmodule : memory_ecc_diag_unit

//--- tb/own_mem_model.sv
// ownership memory model: same-cycle read, registered write
module own_mem_model (
  // clock
  input wire logic i_core_clk,
  // read side
  input wire logic [20:0] i_raddr_a,
  input wire logic [20:0] i_raddr_b,
  output logic [11:0] o_rdata_a,
  output logic [11:0] o_rdata_b,
  // write side
  input wire logic i_we_a,
  input wire logic i_we_b,
  input wire logic [20:0] i_waddr_a,
  input wire logic [20:0] i_waddr_b,
  input wire logic [11:0] i_wdata_a,
  input wire logic [11:0] i_wdata_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // only segments 0..7 kept to stay small; blank cells read as zeros
  logic [11:0] mem [0:32767] = '{default: 12'h000};
  assign o_rdata_a = mem[i_raddr_a[14:0]];
  assign o_rdata_b = mem[i_raddr_b[14:0]];
  // write lands on the edge after the unit raises its strobe
  always @(posedge i_core_clk) begin
    if (i_we_a) mem[i_waddr_a[14:0]] <= i_wdata_a;
    if (i_we_b) mem[i_waddr_b[14:0]] <= i_wdata_b;
  end
endmodule : own_mem_model

//--- tb/tb_top.sv
// self-checking bench of the memory ecc diagnostic unit
`include "memory_ecc_diag_defs.svh"
module tb_top import memory_ecc_diag_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 0, i_resetn = 0, rw, rr, tv, tw, mv, pe, ic, bw, dv, wa, wb;
  logic nre, nhe, mwe, rvl, rco, run;
  logic [1:0] dx, ms;
  logic [7:0] dc, mwc, rsy;
  logic [11:0] ra_d, rb_d, wa_d, wb_d;
  logic [15:0] ra;
  logic [20:0] raa, rab, waa, wab;
  logic [28:0] ta;
  logic [31:0] wd, rd, v;
  logic [63:0] md, dd, mwd, rdd;
  int fails = 0, checks = 0;
  always #25 i_core_clk = ~i_core_clk;
  memory_ecc_diag_unit DUT (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_reg_addr(ra),
    .i_reg_wdata(wd), .i_reg_wr(rw), .i_reg_rd(rr), .o_reg_rdata(rd), .i_txn_valid(tv),
    .i_txn_write(tw), .i_txn_addr(ta), .o_nxm_read_error(nre), .o_nxm_hard_error(nhe),
    .i_mwr_valid(mv), .i_mwr_data(md), .i_mwr_parity_err(pe), .i_mwr_illegal_cmd(ic),
    .i_bad_write_data_cmd(bw), .o_mem_we(mwe), .o_mem_wdata(mwd), .o_mem_wcheck(mwc),
    .o_mode_sel(ms), .i_mrd_valid(dv), .i_mrd_xfer(dx), .i_mrd_data(dd), .i_mrd_check(dc),
    .o_rd_valid(rvl), .o_rd_data(rdd), .o_rd_corrected(rco), .o_rd_uncorrectable(run),
    .o_rd_syndrome(rsy), .o_own_raddr_a(raa), .o_own_raddr_b(rab), .i_own_rdata_a(ra_d),
    .i_own_rdata_b(rb_d), .o_own_we_a(wa), .o_own_we_b(wb), .o_own_waddr_a(waa),
    .o_own_waddr_b(wab), .o_own_wdata_a(wa_d), .o_own_wdata_b(wb_d));
  own_mem_model pm (.i_core_clk(i_core_clk), .i_raddr_a(raa), .i_raddr_b(rab),
    .o_rdata_a(ra_d), .o_rdata_b(rb_d), .i_we_a(wa), .i_we_b(wb), .i_waddr_a(waa),
    .i_waddr_b(wab), .i_wdata_a(wa_d), .i_wdata_b(wb_d));
  task chk(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // spare edge after each write so a window write has landed before the next read
  task wr(input logic [15:0] a, input logic [31:0] d);
    ra <= a;
    wd <= d;
    rw <= 1'b1;
    @(posedge i_core_clk);
    rw <= 1'b0;
    @(posedge i_core_clk);
  endtask : wr
  task rdr(input logic [15:0] a, input logic [31:0] e);
    ra <= a;
    rr <= 1'b1;
    @(posedge i_core_clk);
    rr <= 1'b0;
    #1;
    chk(64'(rd), 64'(e));
    @(posedge i_core_clk);
  endtask : rdr
  task txn(input logic w, input logic [28:0] a, input logic e);
    tv <= 1'b1;
    tw <= w;
    ta <= a;
    @(posedge i_core_clk);
    tv <= 1'b0;
    #1;
    chk(64'({nre, nhe}), w ? 64'(e) : 64'({e, 1'b0}));
    @(posedge i_core_clk);
  endtask : txn
  task mw(input logic [2:0] p, input logic [7:0] e);
    mv <= 1'b1;
    md <= 64'h1;
    {pe, ic, bw} <= p;
    @(posedge i_core_clk);
    mv <= 1'b0;
    #1;
    chk(64'({mwe, mwc}), 64'({1'b1, e}));
    chk(mwd, 64'h1);
    @(posedge i_core_clk);
  endtask : mw
  task mr(input logic [1:0] x, input logic [63:0] d, input logic [7:0] c, input logic [10:0] e);
    dv <= 1'b1;
    dx <= x;
    dd <= d;
    dc <= c;
    @(posedge i_core_clk);
    dv <= 1'b0;
    #1;
    chk(64'({rvl, rco, run, rsy}), 64'(e));
    chk(rdd, 64'h0);
    @(posedge i_core_clk);
  endtask : mr
  task sel(input logic [31:0] d, input logic [1:0] e);
    wr(`MODE_DIAG_OFS, d);
    #1;
    chk(64'(ms), 64'(e));
    @(posedge i_core_clk);
  endtask : sel
  task report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    {ra, wd, rw, rr, tv, tw, ta, mv, md, pe, ic, bw, dv, dx, dd, dc} = '0;
    repeat (6) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    @(posedge i_core_clk);
    // reset values, unmapped place, set matching: 1 Mb set full compare, 4 Mb set top three
    rdr(`MODE_DIAG_OFS, 32'h0);
    rdr(16'h8100, 32'h0);
    wr(16'h8000, 32'h81000001);
    wr(16'h8004, 32'h88000005);
    txn(1'b0, 29'h01000000, 1'b0);
    txn(1'b0, 29'h0b000000, 1'b0);
    txn(1'b0, 29'h02000000, 1'b1);
    txn(1'b1, 29'h10000000, 1'b1);
    $display("address check test done");
    // data bit 0 adds column 0b to the odd-parity bits; each poison source flips the low three
    mw(3'b000, 8'h83);
    for (int i = 0; i < 3; i++) mw(3'(1 << i), 8'h84);
    wr(`MODE_DIAG_OFS, 32'h00005a08);
    mw(3'b000, 8'h5a);
    mw(3'b100, 8'h5d);
    sel(32'h6, 2'h3);
    sel(32'h2, 2'h2);
    sel(32'h4, 2'h0);
    $display("write path test done");
    // only transfers 0 and 1 are captured; bit 0 column flips back
    wr(`MODE_DIAG_OFS, 32'h0);
    mr(2'd0, 64'h0, 8'h88, 11'h400);
    mr(2'd1, 64'h0, 8'h8f, 11'h507);
    mr(2'd2, 64'h0, 8'h8c, 11'h504);
    mr(2'd3, 64'h1, 8'h88, 11'h60b);
    rdr(`MODE_DIAG_OFS, 32'h008f8800);
    wr(`MODE_DIAG_OFS, 32'h1);
    mr(2'd0, 64'h0, 8'h8f, 11'h407);
    $display("read path test done");
    // window modes: forced, fast forced, ecc, reconstruction, blank location
    wr(`OWN_AM_OFS, 32'h00020003);
    wr(16'h0008, 32'h00000abc);
    rdr(16'h0008, 32'h00000abc);
    chk(64'(pm.mem[15'h3001]), 64'habc);
    wr(`OWN_AM_OFS, 32'h00040003);
    wr(16'h0010, 32'h00123456);
    rdr(16'h0010, 32'h00123456);
    chk(64'({pm.mem[15'h3003], pm.mem[15'h3002]}), 64'h123456);
    wr(`OWN_AM_OFS, 32'h00030003);
    wr(16'h0030, 32'h00002001);
    rdr(16'h0030, 32'h00502301);
    wr(`OWN_AM_OFS, 32'h00010003);
    wr(16'h0020, 32'h00000001);
    wr(`OWN_AM_OFS, 32'h00001003);
    chk(64'(pm.mem[15'h3004]), 64'h301);
    wr(16'h0020, 32'h00000001);
    rdr(16'h0020, 32'h00000603);
    wr(`OWN_AM_OFS, 32'h00020003);
    rdr(16'h0400, 32'h0);
    rdr(`OWN_AM_OFS, 32'h02020003);
    $display("ownership window test done");
    report_and_stop;
  end
  // watchdog well beyond the hundred or so cycles the tests need
  initial begin
    repeat (3000) @(posedge i_core_clk);
    fails++;
    report_and_stop;
  end
endmodule : tb_top
